// ==== rtl/isct_pkg.sv ====
/*
 * Package for the SCL timing and interrupt status block: register offsets,
 * reset values, clamp minima, status bit positions and shared types.
 * Assumes a 16-bit count field in a 32-bit register word.
 */
`default_nettype none
package isct_pkg;
    localparam logic [7:0] OFF_FAST_HCNT = 8'h1C;
    localparam logic [7:0] OFF_FAST_LCNT = 8'h20;
    localparam logic [7:0] OFF_HS_HCNT = 8'h24;
    localparam logic [7:0] OFF_HS_LCNT = 8'h28;
    localparam logic [7:0] OFF_INTR_STAT = 8'h2C;
    localparam logic [7:0] OFF_INTR_MASK = 8'h30;
    localparam logic [7:0] OFF_RAW_STAT = 8'h34;
    localparam logic [7:0] OFF_CLR_ALL = 8'h40;
    localparam logic [7:0] OFF_CLR_RX_UNDER = 8'h44;
    localparam logic [7:0] OFF_CLR_RX_OVER = 8'h48;
    localparam logic [7:0] OFF_CLR_TX_OVER = 8'h4C;
    localparam logic [7:0] OFF_CLR_RD_REQ = 8'h50;
    localparam logic [7:0] OFF_CLR_TX_ABRT = 8'h54;
    localparam logic [7:0] OFF_CLR_RX_DONE = 8'h58;
    localparam logic [7:0] OFF_CLR_ACTIVITY = 8'h5C;
    localparam logic [7:0] OFF_CLR_STOP = 8'h60;
    localparam logic [7:0] OFF_CLR_START = 8'h64;
    localparam logic [7:0] OFF_CLR_GEN_CALL = 8'h68;
    localparam logic [15:0] FAST_HCNT_RST = 16'h004B;
    localparam logic [15:0] FAST_LCNT_RST = 16'h00A3;
    localparam logic [15:0] HS_HCNT_RST = 16'h0008;
    localparam logic [15:0] HS_LCNT_RST = 16'h0014;
    localparam logic [15:0] HCNT_MIN = 16'h0006;
    localparam logic [15:0] LCNT_MIN = 16'h0008;
    localparam logic [11:0] MASK_RST = 12'h8FF;
    localparam int STAT_W = 12;
    localparam int B_RX_UNDER = 0;
    localparam int B_RX_OVER = 1;
    localparam int B_RX_FULL = 2;
    localparam int B_TX_OVER = 3;
    localparam int B_TX_EMPTY = 4;
    localparam int B_RD_REQ = 5;
    localparam int B_TX_ABRT = 6;
    localparam int B_RX_DONE = 7;
    localparam int B_ACTIVITY = 8;
    localparam int B_STOP = 9;
    localparam int B_START = 10;
    localparam int B_GEN_CALL = 11;
    localparam logic [1:0] SPEED_STD = 2'h1;
    localparam logic [1:0] SPEED_FAST = 2'h2;
    localparam logic [1:0] SPEED_HIGH = 2'h3;
    typedef struct packed {
        logic gen_call;
        logic start_det;
        logic stop_det;
        logic activity;
        logic rx_done;
        logic tx_abrt;
        logic rd_req;
        logic tx_over;
        logic rx_over;
        logic rx_under;
    } isct_evt_s;
    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
    } isct_cnt_s;
endpackage : isct_pkg
`default_nettype wire

// ==== rtl/isct_sync.sv ====
/*
 * Two-flop level synchroniser, one per bit.
 * Assumes the destination clock runs the enable; the first stage feeds
 * only the second.
 */
`default_nettype none
module isct_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_reg;

    // Two stages, metastability settles in the first
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= '0;
            q_o <= '0;
        end else begin
            s1_reg <= d_i;
            q_o <= s1_reg;
        end
    end
endmodule : isct_sync
`default_nettype wire

// ==== rtl/isct_sclgen.sv ====
/*
 * SCL phase generator in the link clock domain. Counts the programmed
 * high and low cycle counts, which arrive already synchronised and change
 * on count writes while disabled and whenever the speed or special phase selection changes.
 */
`default_nettype none
module isct_sclgen (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire isct_pkg::isct_cnt_s cnt_i,
    output logic scl_o
);
    logic [15:0] cnt_reg;

    // Count a phase, then flip SCL and reload; idle holds SCL high
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 16'h0001;
            scl_o <= 1'b1;
        end else if (!run_i) begin
            cnt_reg <= 16'h0001;
            scl_o <= 1'b1;
        end else if (cnt_reg >= (scl_o ? cnt_i.high : cnt_i.low)) begin
            cnt_reg <= 16'h0001;
            scl_o <= ~scl_o;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule : isct_sclgen
`default_nettype wire

// ==== rtl/isct_top.sv ====
/*
 * SCL timing count registers and interrupt status for the two-wire
 * controller. Holds the fast and high-speed count registers, the mask,
 * raw and masked status words and the clear-on-read registers, and drives
 * an SCL phase generator on the link clock.
 * Assumes the surrounding controller supplies bus events as one-cycle
 * pulses on SYS_CLK_I and FIFO levels and thresholds as same-clock levels.
 */
// Operation
// - Fast high and low count registers set SCL periods at fast speed.
// - High-speed mode uses fast counts for master code, START BYTE, general call.
// - High-speed count registers set SCL periods for high-speed transfers.
// - High count writes below 6 store 6.
// - Low count writes below 8 store 8.
// - Count writes take effect only while the controller is disabled.
// - Standard-only build: fast counts have no storage and read zero.
// - Build without high speed: high-speed counts read zero.
// - Fixed-count build makes every count register read-only.
// - Masked status is raw gated by mask; clear register reads clear it.
// - Bit 11 sets on acknowledged general call; cleared by disable or read.
// - Bit 10 flags START or repeated START, bit 9 flags STOP.
// - Bit 8 captures activity until disable, clear read, or reset.
// - Bit 7 sets when master does not acknowledge slave-transmitted byte.
// - Bit 6 sets on abort, records cause, holds TX flush until cleared.
// - Bit 5 sets on slave read request, holds SCL low until cleared.
// - Bit 4 is set while TX level is at or below threshold.
// - Disabled: bit 4 follows state machine activity only.
// - Bit 3 sets on write to full TX FIFO; disable clears 3,1,0 at idle.
// - Bit 2 is set while RX level at or above threshold, cleared on disable.
// - Bit 1 sets when a byte arrives with RX FIFO full; byte dropped.
// - Bit 0 sets when data register is read with RX FIFO empty.
`default_nettype none
module isct_top #(
    parameter logic [1:0] TOP_SPEED = isct_pkg::SPEED_HIGH,
    parameter bit FIXED_COUNTS = 1'b0
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic CLK_EN_I,
    input wire logic LINK_CLK_I,
    input wire logic LINK_RST_N_I,
    input wire logic REG_SEL_I,
    input wire logic REG_WRITE_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    output logic [31:0] REG_RDATA_O,
    input wire logic CONTROLLER_ENABLED_I,
    input wire logic MACHINES_ACTIVE_I,
    input wire logic [1:0] SPEED_SEL_I,
    input wire logic SPECIAL_PHASE_I,
    input wire logic BUS_RUN_I,
    input wire isct_pkg::isct_evt_s EVT_I,
    input wire logic [7:0] ABORT_CAUSE_I,
    input wire logic [4:0] TX_LEVEL_I,
    input wire logic [4:0] TX_THRESH_I,
    input wire logic [4:0] RX_LEVEL_I,
    input wire logic [4:0] RX_THRESH_I,
    output logic TX_FLUSH_O,
    output logic RX_BYTE_DROP_O,
    output logic SLAVE_STRETCH_O,
    output logic [11:0] INTR_STAT_O,
    output logic SCL_O
);
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;

    // Store a count, lifting it to the floor value
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] m);
        clamp = (v < m) ? m : v;
    endfunction

    // Address match for a register access of either direction
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    logic fast_exist;
    logic hs_exist;
    logic cnt_wr_ok;
    logic wr;
    logic rd;
    assign fast_exist = (TOP_SPEED != isct_pkg::SPEED_STD);
    assign hs_exist = (TOP_SPEED == isct_pkg::SPEED_HIGH);
    assign wr = CLK_EN_I & REG_SEL_I & REG_WRITE_I;
    assign rd = CLK_EN_I & REG_SEL_I & ~REG_WRITE_I;
    assign cnt_wr_ok = wr & ~CONTROLLER_ENABLED_I & ~FIXED_COUNTS;

    logic [15:0] fast_hcnt_reg;
    logic [15:0] fast_lcnt_reg;
    logic [15:0] hs_hcnt_reg;
    logic [15:0] hs_lcnt_reg;

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            fast_hcnt_reg <= isct_pkg::FAST_HCNT_RST;
            fast_lcnt_reg <= isct_pkg::FAST_LCNT_RST;
        end else if (cnt_wr_ok && fast_exist) begin
            if (hit(REG_ADDR_I, isct_pkg::OFF_FAST_HCNT)) begin
                fast_hcnt_reg <= clamp(REG_WDATA_I[15:0], isct_pkg::HCNT_MIN);
            end
            if (hit(REG_ADDR_I, isct_pkg::OFF_FAST_LCNT)) begin
                fast_lcnt_reg <= clamp(REG_WDATA_I[15:0], isct_pkg::LCNT_MIN);
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            hs_hcnt_reg <= isct_pkg::HS_HCNT_RST;
            hs_lcnt_reg <= isct_pkg::HS_LCNT_RST;
        end else if (cnt_wr_ok && hs_exist) begin
            if (hit(REG_ADDR_I, isct_pkg::OFF_HS_HCNT)) begin
                hs_hcnt_reg <= clamp(REG_WDATA_I[15:0], isct_pkg::HCNT_MIN);
            end
            if (hit(REG_ADDR_I, isct_pkg::OFF_HS_LCNT)) begin
                hs_lcnt_reg <= clamp(REG_WDATA_I[15:0], isct_pkg::LCNT_MIN);
            end
        end
    end

    logic [15:0] fast_h_vis;
    logic [15:0] fast_l_vis;
    logic [15:0] hs_h_vis;
    logic [15:0] hs_l_vis;
    assign fast_h_vis = fast_exist ? fast_hcnt_reg : ZERO16;
    assign fast_l_vis = fast_exist ? fast_lcnt_reg : ZERO16;
    assign hs_h_vis = hs_exist ? hs_hcnt_reg : ZERO16;
    assign hs_l_vis = hs_exist ? hs_lcnt_reg : ZERO16;

    logic [11:0] mask_reg;
    // Mask register, freely writable
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mask_reg <= isct_pkg::MASK_RST;
        end else if (wr && hit(REG_ADDR_I, isct_pkg::OFF_INTR_MASK)) begin
            mask_reg <= REG_WDATA_I[11:0];
        end
    end

    // Clear-on-read strobes; combined clear hits every sticky bit
    logic clr_all;
    logic [11:0] clr;
    assign clr_all = rd & hit(REG_ADDR_I, isct_pkg::OFF_CLR_ALL);
    always_comb begin
        clr = '0;
        clr[isct_pkg::B_RX_UNDER] = rd & hit(REG_ADDR_I, isct_pkg::OFF_CLR_RX_UNDER);
        clr[isct_pkg::B_RX_OVER] = rd & hit(REG_ADDR_I, isct_pkg::OFF_CLR_RX_OVER);
        clr[isct_pkg::B_TX_OVER] = rd & hit(REG_ADDR_I, isct_pkg::OFF_CLR_TX_OVER);
        clr[isct_pkg::B_RD_REQ] = rd & hit(REG_ADDR_I, isct_pkg::OFF_CLR_RD_REQ);
        clr[isct_pkg::B_TX_ABRT] = rd & hit(REG_ADDR_I, isct_pkg::OFF_CLR_TX_ABRT);
        clr[isct_pkg::B_RX_DONE] = rd & hit(REG_ADDR_I, isct_pkg::OFF_CLR_RX_DONE);
        clr[isct_pkg::B_ACTIVITY] = rd & hit(REG_ADDR_I, isct_pkg::OFF_CLR_ACTIVITY);
        clr[isct_pkg::B_STOP] = rd & hit(REG_ADDR_I, isct_pkg::OFF_CLR_STOP);
        clr[isct_pkg::B_START] = rd & hit(REG_ADDR_I, isct_pkg::OFF_CLR_START);
        clr[isct_pkg::B_GEN_CALL] = rd & hit(REG_ADDR_I, isct_pkg::OFF_CLR_GEN_CALL);
        clr = clr | {isct_pkg::STAT_W{clr_all}};
    end

    // Event vector lined up with status bit positions; levels 2 and 4 unused
    logic [11:0] evt;
    assign evt = {EVT_I.gen_call, EVT_I.start_det, EVT_I.stop_det, EVT_I.activity,
                  EVT_I.rx_done, EVT_I.tx_abrt, EVT_I.rd_req, 1'b0,
                  EVT_I.tx_over, 1'b0, EVT_I.rx_over, EVT_I.rx_under};

    // Disable clears gen call and activity at once; 3,1,0 wait for idle
    logic [11:0] dis_clr;
    always_comb begin
        dis_clr = '0;
        dis_clr[isct_pkg::B_GEN_CALL] = ~CONTROLLER_ENABLED_I;
        dis_clr[isct_pkg::B_ACTIVITY] = ~CONTROLLER_ENABLED_I;
        dis_clr[isct_pkg::B_TX_OVER] = ~CONTROLLER_ENABLED_I & ~MACHINES_ACTIVE_I;
        dis_clr[isct_pkg::B_RX_OVER] = ~CONTROLLER_ENABLED_I & ~MACHINES_ACTIVE_I;
        dis_clr[isct_pkg::B_RX_UNDER] = ~CONTROLLER_ENABLED_I & ~MACHINES_ACTIVE_I;
    end

    logic [11:0] sticky_reg;
    genvar gi;
    generate
        for (gi = 0; gi < isct_pkg::STAT_W; gi++) begin : g_sticky
            // Set wins over a clear in the same cycle, so no event is lost
            always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
                if (!RST_N_I) begin
                    sticky_reg[gi] <= 1'b0;
                end else if (CLK_EN_I) begin
                    if (evt[gi]) begin
                        sticky_reg[gi] <= 1'b1;
                    end else if (clr[gi] || dis_clr[gi]) begin
                        sticky_reg[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    logic tx_empty;
    logic rx_full;
    assign tx_empty = CONTROLLER_ENABLED_I ? (TX_LEVEL_I <= TX_THRESH_I) : MACHINES_ACTIVE_I;
    assign rx_full = CONTROLLER_ENABLED_I & (RX_LEVEL_I >= RX_THRESH_I);

    logic [11:0] raw;
    always_comb begin
        raw = sticky_reg;
        raw[isct_pkg::B_TX_EMPTY] = tx_empty;
        raw[isct_pkg::B_RX_FULL] = rx_full;
    end

    logic [11:0] stat;
    assign stat = raw & mask_reg;
    assign INTR_STAT_O = stat;

    // flush held until abort bit clears; stretch until serviced
    assign TX_FLUSH_O = sticky_reg[isct_pkg::B_TX_ABRT];
    assign SLAVE_STRETCH_O = sticky_reg[isct_pkg::B_RD_REQ];
    // byte still acknowledged, only storage is refused
    assign RX_BYTE_DROP_O = EVT_I.rx_over;

    logic [7:0] abort_cause_reg;
    // abort cause captured with the event
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            abort_cause_reg <= '0;
        end else if (CLK_EN_I && EVT_I.tx_abrt) begin
            abort_cause_reg <= ABORT_CAUSE_I;
        end else if (CLK_EN_I && clr[isct_pkg::B_TX_ABRT]) begin
            abort_cause_reg <= '0;
        end
    end

    // Read data, registered; unmapped reads return zero
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O <= ZERO32;
        end else if (rd) begin
            case (REG_ADDR_I)
                isct_pkg::OFF_FAST_HCNT: REG_RDATA_O <= {ZERO16, fast_h_vis};
                isct_pkg::OFF_FAST_LCNT: REG_RDATA_O <= {ZERO16, fast_l_vis};
                isct_pkg::OFF_HS_HCNT: REG_RDATA_O <= {ZERO16, hs_h_vis};
                isct_pkg::OFF_HS_LCNT: REG_RDATA_O <= {ZERO16, hs_l_vis};
                isct_pkg::OFF_INTR_STAT: REG_RDATA_O <= {20'h00000, stat};
                isct_pkg::OFF_INTR_MASK: REG_RDATA_O <= {20'h00000, mask_reg};
                isct_pkg::OFF_RAW_STAT: REG_RDATA_O <= {20'h00000, raw};
                isct_pkg::OFF_CLR_TX_ABRT: REG_RDATA_O <= {24'h000000, abort_cause_reg};
                default: REG_RDATA_O <= ZERO32;
            endcase
        end
    end

    // pick counts for the current phase of the transfer
    isct_pkg::isct_cnt_s sel_cnt_reg;
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sel_cnt_reg <= {isct_pkg::FAST_HCNT_RST, isct_pkg::FAST_LCNT_RST};
        end else if (CLK_EN_I) begin
            if (SPEED_SEL_I == isct_pkg::SPEED_HIGH && hs_exist && !SPECIAL_PHASE_I) begin
                sel_cnt_reg <= {hs_h_vis, hs_l_vis};
            end else begin
                sel_cnt_reg <= {fast_h_vis, fast_l_vis};
            end
        end
    end

    // Counts are quasi-static; the run and stretch levels cross through two
    // flops in the same synchroniser as the counts, so all arrive in the same cycle
    logic [33:0] link_q;
    isct_sync #(.W(34)) u_sync (
        .clk_i(LINK_CLK_I),
        .rst_n_i(LINK_RST_N_I),
        .d_i({SLAVE_STRETCH_O, BUS_RUN_I & ~SLAVE_STRETCH_O, sel_cnt_reg}),
        .q_o(link_q)
    );

    // SCL generation on the link clock
    logic scl;
    isct_sclgen u_gen (
        .clk_i(LINK_CLK_I),
        .rst_n_i(LINK_RST_N_I),
        .run_i(link_q[32]),
        .cnt_i(link_q[31:0]),
        .scl_o(scl)
    );
    // stretch pulls SCL low; the pin flop keeps it glitch-free
    logic scl_pin_reg;
    always_ff @(posedge LINK_CLK_I or negedge LINK_RST_N_I) begin
        if (!LINK_RST_N_I) begin
            scl_pin_reg <= 1'b1;
        end else begin
            scl_pin_reg <= scl & ~link_q[33];
        end
    end
    assign SCL_O = scl_pin_reg;

    // stored high counts never below floor
    property p_hcnt_floor;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        fast_hcnt_reg >= isct_pkg::HCNT_MIN && hs_hcnt_reg >= isct_pkg::HCNT_MIN;
    endproperty
    a_hcnt_floor: assert property (p_hcnt_floor) else $error("high count below floor");

    property p_lcnt_floor;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        fast_lcnt_reg >= isct_pkg::LCNT_MIN && hs_lcnt_reg >= isct_pkg::LCNT_MIN;
    endproperty
    a_lcnt_floor: assert property (p_lcnt_floor) else $error("low count below floor");

    property p_locked;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        CONTROLLER_ENABLED_I |=> $stable(fast_hcnt_reg) && $stable(hs_lcnt_reg);
    endproperty
    a_locked: assert property (p_locked) else $error("count changed while enabled");

    property p_mask;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        rd && hit(REG_ADDR_I, isct_pkg::OFF_INTR_STAT)
            |=> REG_RDATA_O[11:0] == $past(raw & mask_reg);
    endproperty
    a_mask: assert property (p_mask) else $error("masked status mismatch");

    property p_set;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        CLK_EN_I && EVT_I.start_det |=> raw[isct_pkg::B_START];
    endproperty
    a_set: assert property (p_set) else $error("start flag not set");

    property p_act_dis;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        CLK_EN_I && !CONTROLLER_ENABLED_I && !EVT_I.activity |=> !raw[isct_pkg::B_ACTIVITY];
    endproperty
    a_act_dis: assert property (p_act_dis) else $error("activity kept after disable");

    property p_flush;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        CLK_EN_I && EVT_I.tx_abrt |=> TX_FLUSH_O && abort_cause_reg == $past(ABORT_CAUSE_I);
    endproperty
    a_flush: assert property (p_flush) else $error("abort not recorded");

    property p_txe;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        !CONTROLLER_ENABLED_I |-> raw[isct_pkg::B_TX_EMPTY] == MACHINES_ACTIVE_I;
    endproperty
    a_txe: assert property (p_txe) else $error("tx empty wrong while disabled");

    property p_rxf;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        !CONTROLLER_ENABLED_I |-> !raw[isct_pkg::B_RX_FULL];
    endproperty
    a_rxf: assert property (p_rxf) else $error("rx full set while disabled");

    property p_ovr_hold;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        CLK_EN_I && !CONTROLLER_ENABLED_I && MACHINES_ACTIVE_I && !clr_all
            && !clr[isct_pkg::B_TX_OVER] && !EVT_I.tx_over |=> $stable(raw[isct_pkg::B_TX_OVER]);
    endproperty
    a_ovr_hold: assert property (p_ovr_hold) else $error("tx over moved before idle");
endmodule : isct_top
`default_nettype wire

// ==== test/isct_scl_peer.sv ====
/*
 * Far-side SCL observer: measures each SCL high and low phase in link
 * clock cycles. Assumes SCL is launched from a flop on the link clock.
 */
`default_nettype none
module isct_scl_peer (
    input wire logic link_clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    output logic [15:0] hi_len_o,
    output logic [15:0] lo_len_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_reg;
    logic [15:0] run_reg;
    // Phase length latched at each edge; idle bus reads as high
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_reg <= 1'b1;
            run_reg <= 16'h0000;
            hi_len_o <= 16'h0000;
            lo_len_o <= 16'h0000;
        end else if (scl_i !== last_reg) begin
            if (last_reg) hi_len_o <= run_reg + 16'h0001;
            else lo_len_o <= run_reg + 16'h0001;
            run_reg <= 16'h0000;
            last_reg <= scl_i;
        end else begin
            run_reg <= run_reg + 16'h0001;
        end
    end
endmodule // isct_scl_peer
`default_nettype wire

// ==== test/i2c_scl_timing_and_irq_status_test.sv ====
/*
 * Self-checking bench for the SCL count registers and interrupt status.
 * Assumes the register strobe is taken at a rising edge with read data
 * registered one cycle later; link clock runs free at 64 ns.
 */
`default_nettype none
module i2c_scl_timing_and_irq_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, lclk = 0, rst_n = 0, sel = 0, we = 0, en = 0, act = 0;
    logic special = 0, run = 0, ce = 1;
    logic [1:0] speed = isct_pkg::SPEED_STD;
    logic [7:0] addr = 8'h00, cause = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rdata_fx;
    logic [9:0] evt = 10'h000;
    logic [4:0] rx_lvl = 5'h00, tx_lvl = 5'h00;
    logic [11:0] stat;
    logic flush, drop, stretch, scl;
    logic [15:0] hi_len, lo_len;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    initial forever #2 clk = ~clk;
    // Odd offset keeps the link clock out of phase with the system clock
    initial begin #7; forever #32 lclk = ~lclk; end
    isct_top uut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(ce), .LINK_CLK_I(lclk),
        .LINK_RST_N_I(rst_n), .REG_SEL_I(sel), .REG_WRITE_I(we), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .CONTROLLER_ENABLED_I(en),
        .MACHINES_ACTIVE_I(act), .SPEED_SEL_I(speed), .SPECIAL_PHASE_I(special),
        .BUS_RUN_I(run), .EVT_I(isct_pkg::isct_evt_s'(evt)), .ABORT_CAUSE_I(cause),
        .TX_LEVEL_I(tx_lvl), .TX_THRESH_I(5'h02), .RX_LEVEL_I(rx_lvl),
        .RX_THRESH_I(5'h02), .TX_FLUSH_O(flush), .RX_BYTE_DROP_O(drop),
        .SLAVE_STRETCH_O(stretch), .INTR_STAT_O(stat), .SCL_O(scl));
    // Second build: fast top speed, counts fixed in hardware
    isct_top #(.TOP_SPEED(isct_pkg::SPEED_FAST), .FIXED_COUNTS(1'b1)) uut_fixed (
        .SYS_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(ce), .LINK_CLK_I(lclk),
        .LINK_RST_N_I(rst_n), .REG_SEL_I(sel), .REG_WRITE_I(we), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata_fx), .CONTROLLER_ENABLED_I(en),
        .MACHINES_ACTIVE_I(act), .SPEED_SEL_I(speed), .SPECIAL_PHASE_I(special),
        .BUS_RUN_I(run), .EVT_I(isct_pkg::isct_evt_s'(evt)), .ABORT_CAUSE_I(cause),
        .TX_LEVEL_I(tx_lvl), .TX_THRESH_I(5'h02), .RX_LEVEL_I(rx_lvl),
        .RX_THRESH_I(5'h02), .TX_FLUSH_O(), .RX_BYTE_DROP_O(), .SLAVE_STRETCH_O(),
        .INTR_STAT_O(), .SCL_O());
    isct_scl_peer peer (.link_clk_i(lclk), .rst_n_i(rst_n), .scl_i(scl),
        .hi_len_o(hi_len), .lo_len_o(lo_len));
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            $display("BAD %s expected %h seen %h", n, e, s);
            error_cnt++;
        end
    endtask
    // whole-word writes, so no byte order can be broken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) {sel, we, addr, wdata} <= {1'b1, 1'b1, a, d};
        @(posedge clk) {sel, we} <= 2'b00;
    endtask
    // Empty name reads without judging, for clear reads of unknown value
    task automatic rd(input logic [7:0] a, input string n, input logic [31:0] e);
        @(posedge clk) {sel, we, addr} <= {1'b1, 1'b0, a};
        @(posedge clk) sel <= 1'b0;
        #1;
        if (n != "") chk(n, e, rdata);
    endtask
    task automatic pulse(input logic [9:0] v);
        @(posedge clk) evt <= v;
        @(posedge clk) evt <= 10'h000;
        #1;
    endtask
    task automatic s_counts();
        logic [15:0] rv [4];
        logic [15:0] cv [4];
        rv = '{isct_pkg::FAST_HCNT_RST, isct_pkg::FAST_LCNT_RST,
               isct_pkg::HS_HCNT_RST, isct_pkg::HS_LCNT_RST};
        cv = '{16'h0006, 16'h0008, 16'h0006, 16'h0008};
        for (int i = 0; i < 4; i++) begin
            rd(8'h1C + 8'(4 * i), "count reset", 32'(rv[i]));
        end
        rd(isct_pkg::OFF_INTR_MASK, "mask reset", 32'h8FF);
        for (int i = 0; i < 4; i++) wr(8'h1C + 8'(4 * i), 32'(i));
        for (int i = 0; i < 4; i++) begin
            rd(8'h1C + 8'(4 * i), "clamped", 32'(cv[i]));
            chk("fixed build", (i < 2) ? 32'(rv[i]) : 32'h0, rdata_fx);
        end
        @(posedge clk) en <= 1'b1;
        wr(isct_pkg::OFF_FAST_HCNT, 32'h100);
        rd(isct_pkg::OFF_FAST_HCNT, "enabled write", 32'h6);
        rd(8'h38, "unmapped", 32'h0);
        @(posedge clk) en <= 1'b0;
    endtask
    task automatic s_status();
        @(posedge clk) en <= 1'b1;
        // Events offered while the clock enable is low must be lost
        @(posedge clk) ce <= 1'b0;
        pulse(10'h080);
        @(posedge clk) ce <= 1'b1;
        pulse(10'h140);
        rd(isct_pkg::OFF_RAW_STAT, "raw", 32'h510);
        rd(isct_pkg::OFF_INTR_STAT, "masked", 32'h010);
        chk("stat port", 32'h010, 32'(stat));
        wr(isct_pkg::OFF_INTR_MASK, 32'hFFF);
        rd(isct_pkg::OFF_INTR_STAT, "unmasked all", 32'h510);
        rd(isct_pkg::OFF_CLR_START, "", 32'h0);
        rd(isct_pkg::OFF_RAW_STAT, "start cleared", 32'h110);
        @(posedge clk) evt <= 10'h007;
        #1 chk("byte drop", 32'h1, 32'(drop));
        @(posedge clk) {evt, rx_lvl, tx_lvl, act} <= {10'h000, 5'h03, 5'h03, 1'b1};
        rd(isct_pkg::OFF_RAW_STAT, "fifo flags", 32'h10F);
        @(posedge clk) en <= 1'b0;
        rd(isct_pkg::OFF_RAW_STAT, "disabled busy", 32'h01B);
        @(posedge clk) act <= 1'b0;
        rd(isct_pkg::OFF_RAW_STAT, "disabled idle", 32'h000);
        @(posedge clk) {rx_lvl, tx_lvl} <= 10'h000;
    endtask
    task automatic s_sticky();
        @(posedge clk) {en, cause} <= {1'b1, 8'h5A};
        pulse(10'h2B8);
        chk("flush", 32'h1, 32'(flush));
        chk("stretch", 32'h1, 32'(stretch));
        rd(isct_pkg::OFF_INTR_STAT, "sticky", 32'hAF0);
        rd(isct_pkg::OFF_CLR_TX_ABRT, "cause", 32'h5A);
        chk("flush off", 32'h0, 32'(flush));
        rd(isct_pkg::OFF_CLR_RD_REQ, "", 32'h0);
        chk("stretch off", 32'h0, 32'(stretch));
        rd(isct_pkg::OFF_CLR_GEN_CALL, "", 32'h0);
        rd(isct_pkg::OFF_RAW_STAT, "partly cleared", 32'h290);
        rd(isct_pkg::OFF_CLR_ALL, "", 32'h0);
        rd(isct_pkg::OFF_RAW_STAT, "cleared", 32'h010);
        @(posedge clk) en <= 1'b0;
    endtask
    task automatic s_scl(input logic [1:0] sp, input logic sf, input logic [15:0] h,
                         input logic [15:0] l);
        @(posedge clk) {speed, special, run} <= {sp, sf, 1'b1};
        repeat (1500) @(posedge clk);
        chk("scl high", 32'(h), 32'(hi_len));
        chk("scl low", 32'(l), 32'(lo_len));
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        s_counts();
        s_status();
        s_sticky();
        wr(isct_pkg::OFF_FAST_HCNT, 32'hA);
        wr(isct_pkg::OFF_FAST_LCNT, 32'hC);
        s_scl(isct_pkg::SPEED_FAST, 1'b0, 16'hA, 16'hC);
        // A read request holds SCL low until its clear register is read
        pulse(10'h008);
        repeat (100) @(posedge clk);
        #1 chk("scl held low", 32'h0, 32'(scl));
        rd(isct_pkg::OFF_CLR_RD_REQ, "", 32'h0);
        s_scl(isct_pkg::SPEED_HIGH, 1'b0, 16'h6, 16'h8);
        s_scl(isct_pkg::SPEED_HIGH, 1'b1, 16'hA, 16'hC);
        summarize();
    end
endmodule // i2c_scl_timing_and_irq_status_test
`default_nettype wire
